/* core/sbc_mode_control.sv */
// Purpose: Mode control register reached over the serial peripheral link.
// Assumes: Link pins are asynchronous and sampled by sys_clk; clock idles low.
// Notes:   power_on_rst_n loads power-on values, rst_n is any chip reset.

// Notes on behaviour
// [R1] A frame with the access lock bit set changes only the stored lock bit and leaves the other fields unchanged.
// [R2] Bits 11:10 select standby, sleep, normal without or with the transceiver supply.
// [R3] Bit 9 set means the next chip reset will drive the limp home output.
// [R4] Every chip reset forces the limp warning arm bit to one.
// [R5] Bit 8 leaves the limp home output floating at zero and drives it low at one.
// [R6] On reset the limp drive bit becomes one only if the arm bit was one before it.
// [R7] The enable output is high only when bit 7 is one and the chip is in normal mode.
// [R8] Bit 6 selects the normal slope at zero and the low slope at one.
// [R9] With bit 5 clear the wake bias floats unsampled, else samples every 16 ms.
// [R10] With bit 5 set the wake bias stays on unsampled, else samples every 64 ms.
// [R11] With bit 4 clear the PNP path turns on at 85 mA and off at 50 mA.
// [R12] With bit 4 set the PNP path turns on at 50 mA and off at 15 mA.
// [R13] A frame holds the address in bits 15:13, the lock bit, then twelve data bits.
// [R14] Input bits are taken on the falling link clock edge and output moves on the rising.
// [R15] Each transfer returns the current register contents while the new word shifts in.
// [R16] The serial data output is driven only while the select input is low.
// [R17] Reserved bits read as zero and the address field as 001, writes to them ignored.
module sbc_mode_control #(
  parameter int SAMPLE_SHORT_CYCLES = sbc_mode_pkg::SAMPLE_SHORT_CYC,
  parameter int SAMPLE_LONG_CYCLES  = sbc_mode_pkg::SAMPLE_LONG_CYC
) (
  input  wire logic                     sys_clk,
  input  wire logic                     rst_n,
  input  wire logic                     power_on_rst_n,
  input  wire logic                     serial_select_n,
  input  wire logic                     serial_clk,
  input  wire logic                     serial_data_in,
  output logic                          serial_data_out,
  output logic                          serial_data_oe,
  input  wire logic                     wake_sample_enable,
  input  wire logic [9:0]               load_current_ma,
  output sbc_mode_pkg::mode_ctrl_t      mode_ctrl,
  output logic                          limp_home_out,
  output logic                          limp_home_oe,
  output logic                          enable_pin_out,
  output logic                          transceiver_supply_on,
  output logic                          lin_slope_low,
  output logic                          wake_bias_out,
  output logic                          wake_bias_oe,
  output logic                          wake_sample_strobe,
  output logic                          pnp_active
);

  // ----------------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------------
  logic [2:0] sync1_q;
  logic [2:0] sync2_q;
  logic       sck_prev_q;
  logic       sel_prev_q;

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      sync1_q    <= 3'h1;
      sync2_q    <= 3'h1;
      sck_prev_q <= 1'b0;
      sel_prev_q <= 1'b1;
    end else begin
      sync1_q    <= {serial_data_in, serial_clk, serial_select_n};
      sync2_q    <= sync1_q;
      sck_prev_q <= sync2_q[1];
      sel_prev_q <= sync2_q[0];
    end
  end

  logic sel_n_s;
  logic sck_s;
  logic sdi_s;
  logic sck_rise;
  logic sck_fall;
  logic sel_start;
  logic sel_end;

  assign sel_n_s   = sync2_q[0];
  assign sck_s     = sync2_q[1];
  assign sdi_s     = sync2_q[2];
  assign sck_rise  = sck_s && !sck_prev_q;
  assign sck_fall  = !sck_s && sck_prev_q;
  assign sel_start = !sel_n_s && sel_prev_q;
  assign sel_end   = sel_n_s && !sel_prev_q;

  // ----------------------------------------------------------------------
  // Register readback image
  // ----------------------------------------------------------------------
  sbc_mode_pkg::mode_ctrl_t regs_q;

  function automatic logic [15:0] read_word(input sbc_mode_pkg::mode_ctrl_t r);
    logic [15:0] w;
    w = '0;
    // [R17] fixed address and reserved bits
    w[sbc_mode_pkg::ADDR_MSB:sbc_mode_pkg::ADDR_LSB] = sbc_mode_pkg::REG_ADDR;
    w[3:0] = sbc_mode_pkg::RESERVED_VAL;
    w[sbc_mode_pkg::LOCK_POS] = r.access_lock;
    w[sbc_mode_pkg::MODE_MSB:sbc_mode_pkg::MODE_LSB] = r.power_mode_select;
    w[sbc_mode_pkg::WARN_POS]   = r.limp_warning_arm;
    w[sbc_mode_pkg::DRIVE_POS]  = r.limp_drive_ctrl;
    w[sbc_mode_pkg::ENABLE_POS] = r.enable_pin_ctrl;
    w[sbc_mode_pkg::SLOPE_POS]  = r.lin_slope_select;
    w[sbc_mode_pkg::WAKE_BIAS_OUT_POS]  = r.wake_bias_ctrl;
    w[sbc_mode_pkg::SHARE_POS]  = r.current_share_ctrl;
    return w;
  endfunction

  // ----------------------------------------------------------------------
  // Serial link state
  // ----------------------------------------------------------------------
  sbc_mode_pkg::link_state_t state_q;
  logic [15:0] shift_in_q;
  logic [15:0] shift_out_q;
  logic [4:0]  bit_cnt_q;

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      state_q <= sbc_mode_pkg::LINK_IDLE;
    end else begin
      case (state_q)
        sbc_mode_pkg::LINK_IDLE: begin
          if (sel_start) begin
            state_q <= sbc_mode_pkg::LINK_XFER;
          end
        end
        sbc_mode_pkg::LINK_XFER: begin
          if (sel_n_s) begin
            state_q <= sbc_mode_pkg::LINK_IDLE;
          end
        end
        default: begin
          state_q <= sbc_mode_pkg::LINK_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      shift_in_q <= 16'h0000;
      bit_cnt_q  <= 5'h00;
    end else if (sel_start) begin
      shift_in_q <= 16'h0000;
      bit_cnt_q  <= 5'h00;
    end else if (state_q == sbc_mode_pkg::LINK_XFER && sck_fall) begin
      // [R14] sample on falling edge
      shift_in_q <= {shift_in_q[14:0], sdi_s};
      if (bit_cnt_q != 5'h1f) begin
        bit_cnt_q <= bit_cnt_q + 5'h01;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      shift_out_q <= 16'h0000;
    end else if (sel_start) begin
      // [R15] load current contents
      shift_out_q <= read_word(regs_q);
    end else if (state_q == sbc_mode_pkg::LINK_XFER && sck_rise && bit_cnt_q != 5'h00) begin
      // [R14] shift on rising edge
      shift_out_q <= {shift_out_q[14:0], 1'b0};
    end
  end

  // [R16] drive only while selected
  assign serial_data_oe  = !sel_n_s && state_q == sbc_mode_pkg::LINK_XFER;
  assign serial_data_out = shift_out_q[15];

  // ----------------------------------------------------------------------
  // Frame decode
  // ----------------------------------------------------------------------
  logic frame_done;
  logic frame_ours;
  logic frame_write;

  // [R13] address then lock then data
  assign frame_done  = sel_end && state_q == sbc_mode_pkg::LINK_XFER
                       && bit_cnt_q == 5'(sbc_mode_pkg::FRAME_BITS);
  assign frame_ours  = shift_in_q[sbc_mode_pkg::ADDR_MSB:sbc_mode_pkg::ADDR_LSB]
                       == sbc_mode_pkg::REG_ADDR;
  // [R1] locked frames store only the lock bit
  assign frame_write = frame_done && frame_ours && !shift_in_q[sbc_mode_pkg::LOCK_POS];

  // ----------------------------------------------------------------------
  // Register storage
  // ----------------------------------------------------------------------
  logic in_rst_q;

  always_ff @(posedge sys_clk) begin
    in_rst_q <= !rst_n;
  end

  always_ff @(posedge sys_clk) begin
    if (!power_on_rst_n) begin
      regs_q.access_lock        <= sbc_mode_pkg::LOCK_RST;
      regs_q.power_mode_select  <= sbc_mode_pkg::MODE_STANDBY;
      regs_q.limp_warning_arm   <= sbc_mode_pkg::WARN_RST;
      regs_q.limp_drive_ctrl    <= sbc_mode_pkg::DRIVE_RST;
      regs_q.enable_pin_ctrl    <= sbc_mode_pkg::ENABLE_RST;
      regs_q.lin_slope_select   <= sbc_mode_pkg::SLOPE_RST;
      regs_q.wake_bias_ctrl     <= sbc_mode_pkg::WAKE_BIAS_OUT_RST;
      regs_q.current_share_ctrl <= sbc_mode_pkg::SHARE_RST;
    end else if (!rst_n) begin
      regs_q.access_lock        <= sbc_mode_pkg::LOCK_RST;
      regs_q.power_mode_select  <= sbc_mode_pkg::MODE_STANDBY;
      // [R4] arm forced on reset
      regs_q.limp_warning_arm   <= 1'b1;
      // [R6] drive follows arm at reset entry
      if (!in_rst_q) begin
        regs_q.limp_drive_ctrl  <= regs_q.limp_warning_arm;
      end
      regs_q.enable_pin_ctrl    <= sbc_mode_pkg::ENABLE_RST;
      regs_q.lin_slope_select   <= sbc_mode_pkg::SLOPE_RST;
      regs_q.wake_bias_ctrl     <= sbc_mode_pkg::WAKE_BIAS_OUT_RST;
      regs_q.current_share_ctrl <= sbc_mode_pkg::SHARE_RST;
    end else if (frame_done && frame_ours) begin
      // [R1] lock bit reflects last access
      regs_q.access_lock <= shift_in_q[sbc_mode_pkg::LOCK_POS];
      if (frame_write) begin
        // [R2] mode selection
        regs_q.power_mode_select <=
          shift_in_q[sbc_mode_pkg::MODE_MSB:sbc_mode_pkg::MODE_LSB];
        // [R3] arm for next reset
        regs_q.limp_warning_arm   <= shift_in_q[sbc_mode_pkg::WARN_POS];
        regs_q.limp_drive_ctrl    <= shift_in_q[sbc_mode_pkg::DRIVE_POS];
        regs_q.enable_pin_ctrl    <= shift_in_q[sbc_mode_pkg::ENABLE_POS];
        regs_q.lin_slope_select   <= shift_in_q[sbc_mode_pkg::SLOPE_POS];
        regs_q.wake_bias_ctrl     <= shift_in_q[sbc_mode_pkg::WAKE_BIAS_OUT_POS];
        regs_q.current_share_ctrl <= shift_in_q[sbc_mode_pkg::SHARE_POS];
      end
    end
  end

  assign mode_ctrl = regs_q;

  // ----------------------------------------------------------------------
  // Mode-dependent pins
  // ----------------------------------------------------------------------
  logic normal_mode;

  assign normal_mode = regs_q.power_mode_select[1];
  assign transceiver_supply_on = regs_q.power_mode_select == sbc_mode_pkg::MODE_NORM_ON;

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      enable_pin_out <= 1'b0;
      lin_slope_low  <= 1'b0;
    end else begin
      // [R7] enable only in normal mode
      enable_pin_out <= regs_q.enable_pin_ctrl && normal_mode;
      // [R8] slope choice
      lin_slope_low  <= regs_q.lin_slope_select;
    end
  end

  // [R5] [R6] limp output pulled low
  always_ff @(posedge sys_clk) begin
    if (!power_on_rst_n) begin
      limp_home_oe <= sbc_mode_pkg::DRIVE_RST;
    end else begin
      limp_home_oe <= regs_q.limp_drive_ctrl;
    end
  end

  assign limp_home_out = 1'b0;

  // ----------------------------------------------------------------------
  // Wake bias and sampling
  // ----------------------------------------------------------------------
  logic [19:0] wake_cnt_q;
  logic [19:0] wake_period;

  assign wake_period = regs_q.wake_bias_ctrl ? 20'(SAMPLE_LONG_CYCLES - 1)
                                             : 20'(SAMPLE_SHORT_CYCLES - 1);

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      wake_cnt_q         <= 20'h00000;
      wake_sample_strobe <= 1'b0;
    end else if (!wake_sample_enable) begin
      wake_cnt_q         <= 20'h00000;
      wake_sample_strobe <= 1'b0;
    end else if (wake_cnt_q >= wake_period) begin
      // [R9] [R10] periodic sampling
      wake_cnt_q         <= 20'h00000;
      wake_sample_strobe <= 1'b1;
    end else begin
      wake_cnt_q         <= wake_cnt_q + 20'h00001;
      wake_sample_strobe <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      wake_bias_oe <= 1'b0;
    end else if (!wake_sample_enable) begin
      // [R9] [R10] static bias choice
      wake_bias_oe <= regs_q.wake_bias_ctrl;
    end else begin
      wake_bias_oe <= wake_cnt_q >= wake_period;
    end
  end

  assign wake_bias_out = 1'b1;

  // ----------------------------------------------------------------------
  // External PNP current sharing
  // ----------------------------------------------------------------------
  logic [9:0] act_th;
  logic [9:0] deact_th;

  // [R11] [R12] threshold pair select
  assign act_th   = regs_q.current_share_ctrl ? sbc_mode_pkg::PNP_ACT_LO_MA
                                              : sbc_mode_pkg::PNP_ACT_HI_MA;
  assign deact_th = regs_q.current_share_ctrl ? sbc_mode_pkg::PNP_DEACT_LO_MA
                                              : sbc_mode_pkg::PNP_DEACT_HI_MA;

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      pnp_active <= 1'b0;
    end else if (!pnp_active && load_current_ma >= act_th) begin
      // [R11] [R12] rising activation
      pnp_active <= 1'b1;
    end else if (pnp_active && load_current_ma <= deact_th) begin
      pnp_active <= 1'b0;
    end
  end

endmodule

/* pkg/sbc_mode_pkg.sv */
// Purpose: Shared constants and types for the mode control register block.
// Assumes: System clock of 10 MHz; register fields as laid out below.
// Notes:   Current thresholds are in milliamperes.
package sbc_mode_pkg;

  // ----------------------------------------------------------------------
  // Frame and register layout
  // ----------------------------------------------------------------------
  localparam int          FRAME_BITS    = 16;
  localparam logic [2:0]  REG_ADDR      = 3'h1;
  localparam int          ADDR_MSB      = 15;
  localparam int          ADDR_LSB      = 13;
  localparam int          LOCK_POS      = 12;
  localparam int          MODE_MSB      = 11;
  localparam int          MODE_LSB      = 10;
  localparam int          WARN_POS      = 9;
  localparam int          DRIVE_POS     = 8;
  localparam int          ENABLE_POS    = 7;
  localparam int          SLOPE_POS     = 6;
  localparam int          WAKE_BIAS_OUT_POS     = 5;
  localparam int          SHARE_POS     = 4;
  localparam logic [3:0]  RESERVED_VAL  = 4'h0;

  // ----------------------------------------------------------------------
  // Operating modes
  // ----------------------------------------------------------------------
  localparam logic [1:0]  MODE_STANDBY  = 2'h0;
  localparam logic [1:0]  MODE_SLEEP    = 2'h1;
  localparam logic [1:0]  MODE_NORM_OFF = 2'h2;
  localparam logic [1:0]  MODE_NORM_ON  = 2'h3;

  // ----------------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------------
  localparam logic        LOCK_RST      = 1'b0;
  localparam logic        WARN_RST      = 1'b1;
  localparam logic        DRIVE_RST     = 1'b0;
  localparam logic        ENABLE_RST    = 1'b0;
  localparam logic        SLOPE_RST     = 1'b0;
  localparam logic        WAKE_BIAS_OUT_RST     = 1'b0;
  localparam logic        SHARE_RST     = 1'b0;

  // ----------------------------------------------------------------------
  // Timing and thresholds
  // ----------------------------------------------------------------------
  localparam int          CLK_HZ        = 10000000;
  localparam int          SAMPLE_SHORT_MS = 16;
  localparam int          SAMPLE_LONG_MS  = 64;
  localparam int          SAMPLE_SHORT_CYC = SAMPLE_SHORT_MS * (CLK_HZ / 1000);
  localparam int          SAMPLE_LONG_CYC  = SAMPLE_LONG_MS * (CLK_HZ / 1000);
  localparam logic [9:0]  PNP_ACT_HI_MA   = 10'd85;
  localparam logic [9:0]  PNP_DEACT_HI_MA = 10'd50;
  localparam logic [9:0]  PNP_ACT_LO_MA   = 10'd50;
  localparam logic [9:0]  PNP_DEACT_LO_MA = 10'd15;

  // ----------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic       access_lock;
    logic [1:0] power_mode_select;
    logic       limp_warning_arm;
    logic       limp_drive_ctrl;
    logic       enable_pin_ctrl;
    logic       lin_slope_select;
    logic       wake_bias_ctrl;
    logic       current_share_ctrl;
  } mode_ctrl_t;

  typedef enum logic [1:0] {
    LINK_IDLE = 2'b01,
    LINK_XFER = 2'b10
  } link_state_t;

endpackage

/* tb/sbc_host_model.sv */
// Purpose: Host side of the serial link, one frame per call.
// Assumes: Link half period is HALF system clock cycles.
// Notes:   Returns the word shifted out by the device.
module sbc_host_model #(
  parameter int HALF = 4
) (
  input  wire logic sys_clk,
  output logic      serial_select_n,
  output logic      serial_clk,
  output logic      serial_data_in,
  input  wire logic serial_data_out
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    serial_select_n = 1'b1;
    serial_clk = 1'b0;
    serial_data_in = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task automatic xfer(input logic [15:0] w, input int nbits, output logic [15:0] rd);
    rd = 16'h0;
    tick(1);
    serial_select_n = 1'b0;
    tick(2 * HALF);
    for (int i = 0; i < nbits; i++) begin
      serial_clk = 1'b1;
      serial_data_in = w[15 - i];
      tick(HALF);
      rd = {rd[14:0], serial_data_out};
      serial_clk = 1'b0;
      tick(HALF);
    end
    serial_select_n = 1'b1;
    serial_data_in = ~serial_data_in;
    tick(2 * HALF);
  endtask
endmodule

/* tb/sbc_mode_control_props.sv */
// Purpose: Concurrent checks on the mode control register ports.
// Assumes: One clock domain, both resets synchronous and active low.
// Notes:   Bound into every instance of the register block.
module sbc_mode_control_props #(
  parameter int SAMPLE_SHORT_CYCLES = 16,
  parameter int SAMPLE_LONG_CYCLES  = 64
) (
  input wire logic                     sys_clk,
  input wire logic                     rst_n,
  input wire logic                     power_on_rst_n,
  input wire logic                     serial_select_n,
  input wire logic                     serial_data_oe,
  input wire logic                     wake_sample_enable,
  input wire logic [9:0]               load_current_ma,
  input wire sbc_mode_pkg::mode_ctrl_t mode_ctrl,
  input wire logic                     limp_home_out,
  input wire logic                     limp_home_oe,
  input wire logic                     enable_pin_out,
  input wire logic                     transceiver_supply_on,
  input wire logic                     lin_slope_low,
  input wire logic                     wake_bias_out,
  input wire logic                     wake_bias_oe,
  input wire logic                     wake_sample_strobe,
  input wire logic                     pnp_active
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n || !power_on_rst_n);
  logic [31:0] gap_q;
  logic        seen_q;
  logic        bias_q;
  logic [9:0]  act_thr;
  logic [9:0]  off_thr;
  assign act_thr = mode_ctrl.current_share_ctrl ? 10'h032 : 10'h055;
  assign off_thr = mode_ctrl.current_share_ctrl ? 10'h00f : 10'h032;
  always_ff @(posedge sys_clk) begin
    bias_q <= mode_ctrl.wake_bias_ctrl;
    gap_q  <= wake_sample_strobe ? 32'h1 : gap_q + 32'h1;
    if (!rst_n || !power_on_rst_n || !wake_sample_enable
        || bias_q != mode_ctrl.wake_bias_ctrl) begin
      seen_q <= 1'b0;
    end else if (wake_sample_strobe) begin
      seen_q <= 1'b1;
    end
  end
  AST_SUPPLY_MODE: assert property (
    transceiver_supply_on == (mode_ctrl.power_mode_select == 2'h3)) else $error("supply mismatch");
  AST_ENABLE_NORMAL: assert property (enable_pin_out ==
    $past(mode_ctrl.enable_pin_ctrl && mode_ctrl.power_mode_select[1]))
    else $error("enable wrong");
  AST_SLOPE: assert property (
    lin_slope_low == $past(mode_ctrl.lin_slope_select)) else $error("slope wrong");
  AST_LIMP_DRIVE: assert property (!limp_home_out &&
    limp_home_oe == $past(mode_ctrl.limp_drive_ctrl)) else $error("limp output wrong");
  AST_ARM_ON_RESET: assert property (disable iff (!power_on_rst_n)
    $rose(rst_n) |-> mode_ctrl.limp_warning_arm) else $error("arm not set by reset");
  AST_DRIVE_ON_RESET: assert property (disable iff (!power_on_rst_n) $fell(rst_n) |=>
    mode_ctrl.limp_drive_ctrl == $past(mode_ctrl.limp_warning_arm)) else $error("drive wrong");
  AST_WAKE_BIAS_IDLE: assert property (
    (!wake_sample_enable && $stable(mode_ctrl)) [*3]
    |-> wake_bias_out && wake_bias_oe == mode_ctrl.wake_bias_ctrl) else $error("wake bias wrong");
  AST_WAKE_PERIOD: assert property (wake_sample_strobe && seen_q |-> gap_q ==
    (mode_ctrl.wake_bias_ctrl ? SAMPLE_LONG_CYCLES : SAMPLE_SHORT_CYCLES)) else $error("period");
  AST_PNP_ON: assert property (
    !pnp_active && load_current_ma >= act_thr |=> pnp_active) else $error("pnp not on");
  AST_PNP_OFF: assert property (
    pnp_active && load_current_ma <= off_thr |=> !pnp_active) else $error("pnp not off");
  AST_OE_IDLE: assert property (
    serial_select_n [*5] |-> !serial_data_oe) else $error("output driven while idle");
  AST_OE_ACTIVE: assert property (
    (!serial_select_n) [*5] |-> serial_data_oe) else $error("output not driven while selected");
  cover property ($fell(serial_select_n));
  cover property (wake_sample_strobe && seen_q);
  cover property ($rose(pnp_active));
endmodule

bind sbc_mode_control sbc_mode_control_props #(
  .SAMPLE_SHORT_CYCLES(SAMPLE_SHORT_CYCLES),
  .SAMPLE_LONG_CYCLES(SAMPLE_LONG_CYCLES)
) i_sbc_mode_control_props (
  .sys_clk, .rst_n, .power_on_rst_n, .serial_select_n, .serial_data_oe,
  .wake_sample_enable, .load_current_ma, .mode_ctrl, .limp_home_out, .limp_home_oe,
  .enable_pin_out, .transceiver_supply_on, .lin_slope_low, .wake_bias_out, .wake_bias_oe,
  .wake_sample_strobe, .pnp_active
);

/* tb/test_sbc_mode_control.sv */
// Purpose: Self-checking bench for the mode control register.
// Assumes: Short wake sample periods of 16 and 64 cycles.
// Notes:   The expected register contents are kept in exp_q.
module test_sbc_mode_control;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int SHORT = 16;
  localparam int LONG  = 64;
  logic       sys_clk = 1'b0;
  logic       rst_n = 1'b0;
  logic       power_on_rst_n = 1'b0;
  logic       serial_select_n;
  logic       serial_clk;
  logic       serial_data_in;
  logic       serial_data_out;
  logic       serial_data_oe;
  logic       wake_sample_enable = 1'b0;
  logic [9:0] load_current_ma = 10'h000;
  logic       limp_home_oe;
  logic       enable_pin_out;
  logic       transceiver_supply_on;
  logic       lin_slope_low;
  logic       wake_bias_oe;
  logic       wake_sample_strobe;
  logic       pnp_active;
  logic [15:0] exp_q = 16'h2200;
  logic [15:0] rd;
  int         n_errors = 0;
  int         samples_checked = 0;
  always #50 sys_clk = ~sys_clk;
  sbc_mode_control #(.SAMPLE_SHORT_CYCLES(SHORT), .SAMPLE_LONG_CYCLES(LONG)) i_sbc_mode_control (
    .sys_clk, .rst_n, .power_on_rst_n, .serial_select_n, .serial_clk, .serial_data_in,
    .serial_data_out, .serial_data_oe, .wake_sample_enable, .load_current_ma, .mode_ctrl(),
    .limp_home_out(), .limp_home_oe, .enable_pin_out, .transceiver_supply_on, .lin_slope_low,
    .wake_bias_out(), .wake_bias_oe, .wake_sample_strobe, .pnp_active
  );
  sbc_host_model i_sbc_host_model (
    .sys_clk, .serial_select_n, .serial_clk, .serial_data_in, .serial_data_out
  );
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic check_bit(input string what, input logic exp, input logic got);
    check(what, {15'h0, exp}, {15'h0, got});
  endtask
  task automatic wrap_up();
    $display("Comparisons %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic frame(input logic [15:0] w, input int nbits);
    logic own;
    own = nbits == 16 && w[15:13] == 3'h1;
    i_sbc_host_model.xfer(w, nbits, rd);
    if (own) check("readback", exp_q, rd);
    if (own) exp_q = w[12] ? {exp_q[15:13], 1'b1, exp_q[11:0]} : {3'h1, w[12:4], 4'h0};
    check_bit("oe idle", 1'b0, serial_data_oe);
    check_bit("supply", exp_q[11:10] == 2'h3, transceiver_supply_on);
    check_bit("enable", exp_q[7] & exp_q[11], enable_pin_out);
    check_bit("slope", exp_q[6], lin_slope_low);
    check_bit("limp", exp_q[8], limp_home_oe);
    if (!wake_sample_enable) check_bit("bias", exp_q[5], wake_bias_oe);
  endtask
  task automatic pulse_rst(input logic [15:0] e);
    rst_n = 1'b0;
    repeat (2) @(posedge sys_clk);
    #1;
    rst_n = 1'b1;
    repeat (4) @(posedge sys_clk);
    #1;
    exp_q = e;
  endtask
  task automatic measure(input int p);
    int n;
    int k;
    n = 0;
    k = 0;
    while (wake_sample_strobe !== 1'b1 && k < 200) begin
      @(posedge sys_clk);
      #1;
      k++;
    end
    do begin
      @(posedge sys_clk);
      #1;
      n++;
    end while (wake_sample_strobe !== 1'b1 && n < 200);
    check("period", p[15:0], n[15:0]);
  endtask
  task automatic pnp(input logic [9:0] l, input logic e);
    load_current_ma = l;
    repeat (3) @(posedge sys_clk);
    #1;
    check_bit("pnp", e, pnp_active);
  endtask
  initial begin
    repeat (2) @(posedge sys_clk);
    #1;
    rst_n = 1'b1;
    power_on_rst_n = 1'b1;
    repeat (4) @(posedge sys_clk);
    #1;
    frame(16'h3000, 16);
    for (int m = 0; m < 4; m++) frame({4'h2, m[1:0], 3'b001, m[0], 2'b00, 4'hf}, 16);
    frame(16'h4000, 16);
    frame(16'h2000, 12);
    frame(16'h3000, 16);
    frame(16'h2000, 16);
    pulse_rst(16'h2200);
    frame(16'h2200, 16);
    pulse_rst(16'h2300);
    check_bit("limp", 1'b1, limp_home_oe);
    frame(16'h2100, 16);
    frame(16'h2020, 16);
    wake_sample_enable = 1'b1;
    measure(LONG);
    wake_sample_enable = 1'b0;
    frame(16'h2000, 16);
    wake_sample_enable = 1'b1;
    measure(SHORT);
    wake_sample_enable = 1'b0;
    pnp(10'h054, 1'b0);
    pnp(10'h055, 1'b1);
    pnp(10'h033, 1'b1);
    pnp(10'h032, 1'b0);
    pnp(10'h000, 1'b0);
    frame(16'h2010, 16);
    pnp(10'h031, 1'b0);
    pnp(10'h032, 1'b1);
    pnp(10'h010, 1'b1);
    pnp(10'h00f, 1'b0);
    wrap_up();
  end
  // The tests need about 2200 cycles; the limit of 20000 cycles leaves a wide margin.
  initial begin
    #2000000;
    n_errors++;
    wrap_up();
  end
endmodule
